// >>> core/pfs_pkg.sv
// Purpose: constants for the pin function and strap control block
// Assumes: one system clock, plain register port
// Notes:   offsets are word addresses on the register port
package pfs_pkg;
  // ==========================================================
  // port 1 modes
  typedef enum logic [3:0] {
    PFS_MODE_MII_MAC  = 4'h1,
    PFS_MODE_MII_PHY  = 4'h2,
    PFS_MODE_RMII     = 4'h4,
    PFS_MODE_INTERNAL = 4'h8
  } pfs_mode_e;
  localparam logic [1:0] PFS_MSEL_MII_MAC  = 2'h0;
  localparam logic [1:0] PFS_MSEL_MII_PHY  = 2'h1;
  localparam logic [1:0] PFS_MSEL_RMII     = 2'h2;
  localparam logic [1:0] PFS_MSEL_INTERNAL = 2'h3;
  // ==========================================================
  // register offsets
  localparam logic [3:0] PFS_OFF_PORT_CTRL = 4'h0;
  localparam logic [3:0] PFS_OFF_GP_CFG    = 4'h1;
  localparam logic [3:0] PFS_OFF_GP_DIR    = 4'h2;
  localparam logic [3:0] PFS_OFF_IND_CFG   = 4'h3;
  localparam logic [3:0] PFS_OFF_STATUS    = 4'h4;
  localparam logic [3:0] PFS_OFF_SOFTSTRAP = 4'h5;
  // ==========================================================
  // field positions
  localparam int PFS_BIT_MODE_LO  = 0;
  localparam int PFS_BIT_ISOLATE  = 2;
  localparam int PFS_BIT_DIR_LO   = 0;
  localparam int PFS_BIT_DATA_LO  = 8;
  localparam int PFS_BIT_FUN_LO   = 0;
  localparam int PFS_BIT_IND5_EN  = 8;
  localparam int PFS_BIT_EE_DONE  = 0;
  localparam int PFS_BIT_STRAP_LO = 8;
  // ==========================================================
  // reset values
  localparam logic [1:0] PFS_RST_MODE    = 2'h0;
  localparam logic [2:0] PFS_RST_GP      = 3'h0;
  localparam logic [2:0] PFS_RST_FUN     = 3'h0;
  localparam logic       PFS_RST_IND5_EN = 1'h0;
  // indicator functions whose output is open-drain/open-source
  localparam logic [7:0] PFS_FUN_OPEN_MASK = 8'hf0;
  // ==========================================================
  // timing: strap capture one cycle after reset release
  localparam int PFS_STRAP_DELAY_CYC = 1;
endpackage

// >>> core/pfs_gp_pin.sv
// Purpose: one general-purpose pin cell
// Assumes: inputs synchronous to clock
// Notes:   push-pull, open-drain or input
`timescale 1ns/1ps
module pfs_gp_pin
  import pfs_pkg::*;
(
  // clock and reset
  input  wire logic clock,
  input  wire logic reset_n,
  // control
  input  wire logic is_output,
  input  wire logic open_drain,
  input  wire logic out_value,
  // pin
  input  wire logic pin_in,
  output logic      pin_out,
  output logic      pin_oe,
  output logic      pin_sensed
);
  // ==========================================================
  // registered drive
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pin_out <= 1'b0;
      pin_oe  <= 1'b0;
    end else begin
      pin_out <= open_drain ? 1'b0 : out_value;
      pin_oe  <= is_output & (open_drain ? ~out_value : 1'b1);
    end
  end
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pin_sensed <= 1'b0;
    end else begin
      pin_sensed <= pin_in;
    end
  end
endmodule // pfs_gp_pin

// >>> core/pfs_pin_ctrl.sv
// Purpose: pin function selection, output enables and strap capture
// Assumes: registers reached over a plain strobe port, read data a cycle later
// Notes:   two-way pins are split into in, out and output enable
`timescale 1ns/1ps
module pfs_pin_ctrl
  import pfs_pkg::*;
#(
  parameter int GP_COUNT = 3
)
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        reset_n,
  // register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [31:0] reg_rdata,
  // switch core side
  input  wire logic        core_collision,
  input  wire logic        core_carrier,
  output logic             sensed_collision,
  input  wire logic        eeprom_loaded,
  input  wire logic        eeprom_active,
  input  wire logic        eeprom_clock_drive_low,
  input  wire logic        eeprom_data_drive_low,
  output logic             eeprom_clock_sensed,
  output logic             eeprom_data_sensed,
  input  wire logic        slave_data_drive_low,
  output logic             slave_data_sensed,
  output logic             slave_clock_sensed,
  input  wire logic        indicator_5_value,
  output logic             phy_address_select,
  // port 1 pins
  input  wire logic        port1_collision_pin_in,
  output logic             port1_collision_pin_out,
  output logic             port1_collision_pin_oe,
  output logic             port1_carrier_sense_pin_out,
  output logic             port1_carrier_sense_pin_oe,
  // serial pins
  input  wire logic        slave_serial_clock_pin,
  input  wire logic        slave_serial_data_pin_in,
  output logic             slave_serial_data_pin_out,
  output logic             slave_serial_data_pin_oe,
  input  wire logic        eeprom_clock_pin_in,
  output logic             eeprom_clock_pin_out,
  output logic             eeprom_clock_pin_oe,
  input  wire logic        eeprom_data_pin_in,
  output logic             eeprom_data_pin_out,
  output logic             eeprom_data_pin_oe,
  // general pins, bit 0 is pin 5 shared with indicator 5
  input  wire logic [2:0]  general_pin_in,
  output logic      [2:0]  general_pin_out,
  output logic      [2:0]  general_pin_oe
);
  // ==========================================================
  // registers
  logic [1:0] mode_reg;
  logic       isolate_reg;
  logic [2:0] gp_open_reg;
  logic [2:0] gp_dir_reg;
  logic [2:0] gp_data_reg;
  logic [2:0] fun_reg;
  logic       ind5_en_reg;
  logic       strap_reg;
  logic       strap_pending_reg;
  logic       phy_sel_reg;
  pfs_mode_e  mode_oh_reg;
  logic [2:0] gp_sensed;
  logic [2:0] gp_pin_out;
  logic [2:0] gp_pin_oe;
  logic       ind_out_reg;
  logic       ind_oe_reg;
  logic       ind_open;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      mode_reg    <= PFS_RST_MODE;
      isolate_reg <= 1'b0;
    end else if (reg_write && reg_addr == PFS_OFF_PORT_CTRL) begin
      mode_reg    <= reg_wdata[PFS_BIT_MODE_LO +: 2];
      isolate_reg <= reg_wdata[PFS_BIT_ISOLATE];
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      gp_open_reg <= PFS_RST_GP;
      gp_dir_reg  <= PFS_RST_GP;
      gp_data_reg <= PFS_RST_GP;
    end else if (reg_write && reg_addr == PFS_OFF_GP_CFG) begin
      gp_open_reg <= reg_wdata[2:0];
    end else if (reg_write && reg_addr == PFS_OFF_GP_DIR) begin
      gp_dir_reg  <= reg_wdata[PFS_BIT_DIR_LO +: 3];
      gp_data_reg <= reg_wdata[PFS_BIT_DATA_LO +: 3];
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      fun_reg     <= PFS_RST_FUN;
      ind5_en_reg <= PFS_RST_IND5_EN;
    end else if (reg_write && reg_addr == PFS_OFF_IND_CFG) begin
      fun_reg     <= reg_wdata[PFS_BIT_FUN_LO +: 3];
      ind5_en_reg <= reg_wdata[PFS_BIT_IND5_EN];
    end
  end

  // ==========================================================
  // strap capture after every reset release
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      strap_pending_reg <= 1'b1;
      strap_reg         <= 1'b0;
    end else if (strap_pending_reg) begin
      strap_pending_reg <= 1'b0;
      strap_reg         <= general_pin_in[0];
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      phy_sel_reg <= 1'b0;
    end else if (strap_pending_reg) begin
      phy_sel_reg <= general_pin_in[0];
    end else if (reg_write && reg_addr == PFS_OFF_SOFTSTRAP) begin
      phy_sel_reg <= reg_wdata[0];
    end
  end
  assign phy_address_select = phy_sel_reg;

  // ==========================================================
  // port 1 collision and carrier sense
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      mode_oh_reg <= PFS_MODE_MII_MAC;
    end else begin
      unique case (mode_reg)
        PFS_MSEL_MII_MAC:  mode_oh_reg <= PFS_MODE_MII_MAC;
        PFS_MSEL_MII_PHY:  mode_oh_reg <= PFS_MODE_MII_PHY;
        PFS_MSEL_RMII:     mode_oh_reg <= PFS_MODE_RMII;
        PFS_MSEL_INTERNAL: mode_oh_reg <= PFS_MODE_INTERNAL;
      endcase
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      port1_collision_pin_out     <= 1'b0;
      port1_collision_pin_oe      <= 1'b0;
      port1_carrier_sense_pin_out <= 1'b0;
      port1_carrier_sense_pin_oe  <= 1'b0;
      sensed_collision            <= 1'b0;
    end else begin
      port1_collision_pin_out     <= core_collision;
      port1_carrier_sense_pin_out <= core_carrier;
      port1_collision_pin_oe      <= (mode_reg == PFS_MSEL_MII_PHY) & ~isolate_reg;
      port1_carrier_sense_pin_oe  <= (mode_reg == PFS_MSEL_MII_PHY) & ~isolate_reg;
      sensed_collision            <= (mode_reg == PFS_MSEL_MII_MAC) &
                                     port1_collision_pin_in;
    end
  end

  // ==========================================================
  // serial bus pins
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      slave_serial_data_pin_out <= 1'b0;
      slave_serial_data_pin_oe  <= 1'b0;
      slave_data_sensed         <= 1'b1;
      slave_clock_sensed        <= 1'b1;
    end else begin
      slave_serial_data_pin_out <= 1'b0;
      slave_serial_data_pin_oe  <= eeprom_loaded & slave_data_drive_low;
      slave_data_sensed         <= eeprom_loaded ? slave_serial_data_pin_in : 1'b1;
      slave_clock_sensed        <= eeprom_loaded ? slave_serial_clock_pin : 1'b1;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      eeprom_clock_pin_out <= 1'b0;
      eeprom_clock_pin_oe  <= 1'b0;
      eeprom_data_pin_out  <= 1'b0;
      eeprom_data_pin_oe   <= 1'b0;
      eeprom_clock_sensed  <= 1'b1;
      eeprom_data_sensed   <= 1'b1;
    end else begin
      eeprom_clock_pin_out <= 1'b0;
      eeprom_data_pin_out  <= 1'b0;
      eeprom_clock_pin_oe  <= eeprom_active & eeprom_clock_drive_low;
      eeprom_data_pin_oe   <= eeprom_active & eeprom_data_drive_low;
      eeprom_clock_sensed  <= eeprom_clock_pin_in;
      eeprom_data_sensed   <= eeprom_data_pin_in;
    end
  end

  // ==========================================================
  // general pins
  for (genvar i = 0; i < GP_COUNT; i++) begin : g_gp
    pfs_gp_pin u_pin (
      .clock      (clock),
      .reset_n    (reset_n),
      .is_output  (gp_dir_reg[i]),
      .open_drain (gp_open_reg[i]),
      .out_value  (gp_data_reg[i]),
      .pin_in     (general_pin_in[i]),
      .pin_out    (gp_pin_out[i]),
      .pin_oe     (gp_pin_oe[i]),
      .pin_sensed (gp_sensed[i])
    );
  end

  // ==========================================================
  // indicator 5
  assign ind_open = PFS_FUN_OPEN_MASK[fun_reg];
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ind_out_reg <= 1'b0;
      ind_oe_reg  <= 1'b0;
    end else if (ind_open) begin
      ind_out_reg <= strap_reg;
      ind_oe_reg  <= indicator_5_value;
    end else begin
      ind_out_reg <= indicator_5_value ^ strap_reg;
      ind_oe_reg  <= 1'b1;
    end
  end

  logic ind5_sel_reg;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ind5_sel_reg <= 1'b0;
    end else begin
      ind5_sel_reg <= ind5_en_reg;
    end
  end

  assign general_pin_out[0]   = ind5_sel_reg ? ind_out_reg : gp_pin_out[0];
  assign general_pin_oe[0]    = ind5_sel_reg ? ind_oe_reg : gp_pin_oe[0];
  assign general_pin_out[2:1] = gp_pin_out[2:1];
  assign general_pin_oe[2:1]  = gp_pin_oe[2:1];

  // ==========================================================
  // register reads
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 32'h0;
    end else if (reg_read) begin
      unique case (reg_addr)
        PFS_OFF_PORT_CTRL: reg_rdata <= {29'h0, isolate_reg, mode_reg};
        PFS_OFF_GP_CFG:    reg_rdata <= {29'h0, gp_open_reg};
        PFS_OFF_GP_DIR:    reg_rdata <= {13'h0, gp_sensed, 5'h0, gp_data_reg,
                                         5'h0, gp_dir_reg};
        PFS_OFF_IND_CFG:   reg_rdata <= {23'h0, ind5_en_reg, 5'h0, fun_reg};
        PFS_OFF_STATUS:    reg_rdata <= {23'h0, strap_reg, 7'h0, eeprom_loaded};
        PFS_OFF_SOFTSTRAP: reg_rdata <= {31'h0, phy_sel_reg};
        default:           reg_rdata <= 32'h0;
      endcase
    end else begin
      reg_rdata <= 32'h0;
    end
  end
endmodule // pfs_pin_ctrl

// >>> sim/pfs_pin_ctrl_props.sv
// Purpose: port checker for pfs_pin_ctrl
// Assumes: one clock, async active-low reset
// Notes:   port control shadowed from register writes
`timescale 1ns/1ps
module pfs_pin_ctrl_props
  import pfs_pkg::*;
(
  // clock, reset, register writes
  input wire logic        clock,
  input wire logic        reset_n,
  input wire logic [3:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_write,
  // pins and core side
  input wire logic        port1_collision_pin_in,
  input wire logic        port1_collision_pin_oe,
  input wire logic        port1_carrier_sense_pin_oe,
  input wire logic        sensed_collision,
  input wire logic        eeprom_loaded,
  input wire logic        slave_serial_data_pin_oe,
  input wire logic        slave_serial_data_pin_out,
  input wire logic        slave_data_sensed,
  input wire logic        eeprom_clock_pin_out,
  input wire logic        eeprom_data_pin_out,
  input wire logic        eeprom_data_pin_in,
  input wire logic        eeprom_data_sensed,
  input wire logic [2:0]  general_pin_in,
  input wire logic        phy_address_select
);
  // ==========
  // shadow of port control, cycles since reset
  logic [2:0] ctrl_reg;
  logic [1:0] cyc_reg;
  logic       drive_on, mac_on, idle_on, strap_pin;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_reg <= 3'h0;
    end else if (reg_write && reg_addr == PFS_OFF_PORT_CTRL) begin
      ctrl_reg <= reg_wdata[2:0];
    end
  end
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cyc_reg <= 2'h0;
    end else if (cyc_reg != 2'h2) begin
      cyc_reg <= cyc_reg + 2'h1;
    end
  end
  assign drive_on  = ctrl_reg[1:0] == PFS_MSEL_MII_PHY && !ctrl_reg[2];
  assign mac_on    = ctrl_reg[1:0] == PFS_MSEL_MII_MAC;
  assign idle_on   = ctrl_reg[1];
  assign strap_pin = general_pin_in[0];
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  // ==========
  // assertions
  a_collision_drive:
    assert property (port1_collision_pin_oe == $past(drive_on)) else $error("collision enable");
  a_carrier_drive:
    assert property (port1_carrier_sense_pin_oe == $past(drive_on)) else $error("carrier enable");
  a_rmii_unused:
    assert property ($past(idle_on) |-> !port1_collision_pin_oe &&
      !port1_carrier_sense_pin_oe && !sensed_collision)
    else $error("unused pin active");
  a_mac_sense:
    assert property (cyc_reg != 2'h0 && $past(mac_on) |->
      sensed_collision == $past(port1_collision_pin_in)) else $error("collision not sensed");
  a_slave_quiet:
    assert property (!eeprom_loaded && !$past(eeprom_loaded) |->
      !slave_serial_data_pin_oe && slave_data_sensed) else $error("slave pin active early");
  a_open_drain:
    assert property (!slave_serial_data_pin_out && !eeprom_clock_pin_out && !eeprom_data_pin_out)
    else $error("open-drain line driven high");
  a_ee_sense:
    assert property (cyc_reg != 2'h0 |-> eeprom_data_sensed == $past(eeprom_data_pin_in))
    else $error("eeprom data not sensed");
  a_strap_take:
    assert property (cyc_reg == 2'h1 |-> phy_address_select == $past(strap_pin))
    else $error("strap not captured");
endmodule // pfs_pin_ctrl_props

bind pfs_pin_ctrl pfs_pin_ctrl_props chk_u (.*);

// >>> sim/pfs_far_side.sv
// Purpose: far side: external PHY, serial master, EEPROM, pull-ups
// Assumes: every open-drain and general line has a pull-up
// Notes:   a released line settles at its pull-up level
`timescale 1ns/1ps
module pfs_far_side (
  // far-side stimulus
  input wire logic       phy_collision,
  input wire logic       master_clock,
  input wire logic       master_data_low,
  input wire logic       eeprom_data_low,
  input wire logic [2:0] ext_enable,
  input wire logic [2:0] ext_value,
  // design drivers
  input wire logic       port1_collision_pin_out,
  input wire logic       port1_collision_pin_oe,
  input wire logic       slave_serial_data_pin_out,
  input wire logic       slave_serial_data_pin_oe,
  input wire logic       eeprom_clock_pin_out,
  input wire logic       eeprom_clock_pin_oe,
  input wire logic       eeprom_data_pin_out,
  input wire logic       eeprom_data_pin_oe,
  input wire logic [2:0] general_pin_out,
  input wire logic [2:0] general_pin_oe,
  // resolved line levels
  output logic           port1_collision_pin_in,
  output logic           slave_serial_clock_pin,
  output logic           slave_serial_data_pin_in,
  output logic           eeprom_clock_pin_in,
  output logic           eeprom_data_pin_in,
  output logic     [2:0] general_pin_in
);
  // ==========
  // line resolution
  assign port1_collision_pin_in =
    port1_collision_pin_oe ? port1_collision_pin_out : phy_collision;
  assign slave_serial_clock_pin = master_clock;
  assign slave_serial_data_pin_in =
    !(slave_serial_data_pin_oe && !slave_serial_data_pin_out) && !master_data_low;
  assign eeprom_clock_pin_in = !(eeprom_clock_pin_oe && !eeprom_clock_pin_out);
  assign eeprom_data_pin_in =
    !(eeprom_data_pin_oe && !eeprom_data_pin_out) && !eeprom_data_low;
  assign general_pin_in = (general_pin_oe & general_pin_out) |
    (~general_pin_oe & (~ext_enable | ext_value));
endmodule // pfs_far_side

// >>> sim/pin_function_and_strap_control_bench.sv
// Purpose: self-checking bench for pin function and strap control
// Assumes: far-side model resolves every shared line
// Notes:   expectations come from a shadow register model
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end
module pin_function_and_strap_control_bench
  import pfs_pkg::*;
;
  // ==========
  // signals and model
  logic        clock, reset_n, reg_write, reg_read, core_collision, core_carrier;
  logic        eeprom_loaded, eeprom_active, eeprom_clock_drive_low, eeprom_data_drive_low;
  logic        slave_data_drive_low, indicator_5_value, phy_collision, master_clock;
  logic        master_data_low, eeprom_data_low;
  logic [2:0]  ext_enable, ext_value;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata, rnd;
  wire  [31:0] reg_rdata;
  wire         sensed_collision, eeprom_clock_sensed, eeprom_data_sensed, slave_data_sensed;
  wire         slave_clock_sensed, phy_address_select, port1_collision_pin_out;
  wire         port1_collision_pin_oe, port1_carrier_sense_pin_out, port1_carrier_sense_pin_oe;
  wire         slave_serial_data_pin_out, slave_serial_data_pin_oe, eeprom_clock_pin_out;
  wire         eeprom_clock_pin_oe, eeprom_data_pin_out, eeprom_data_pin_oe;
  wire         port1_collision_pin_in, slave_serial_clock_pin, slave_serial_data_pin_in;
  wire         eeprom_clock_pin_in, eeprom_data_pin_in;
  wire  [2:0]  general_pin_out, general_pin_oe, general_pin_in;
  int          n_mismatch = 0, check_count = 0, strap, regs[16];
  int          wmask[16] = '{7, 7, 32'h707, 32'h107, 0, 1, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0};
  pfs_pin_ctrl dut_u (.*);
  pfs_far_side far_u (.*);
  function automatic logic [1:0] exp_gp(input int i);
    if (i == 0 && regs[3][8]) begin
      return regs[3][2] ? {indicator_5_value, strap[0]} : {1'b1, indicator_5_value ^ strap[0]};
    end
    if (!regs[2][i]) begin
      return 2'h0;
    end
    return regs[1][i] ? {~regs[2][8+i], 1'b0} : {1'b1, regs[2][8+i]};
  endfunction
  function automatic logic lvl(input int i);
    logic [1:0] g;
    g = exp_gp(i);
    return g[1] ? g[0] : (!ext_enable[i] || ext_value[i]);
  endfunction
  // ==========
  // bus, reset and pin tasks
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_write <= 1'b0;
    if (wmask[a] != 0) regs[a] = d & wmask[a];
  endtask
  task automatic rd(input logic [3:0] a);
    int e;
    @(posedge clock);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_read <= 1'b0;
    e = regs[a];
    if (a == PFS_OFF_GP_DIR) e = e | (int'({lvl(2), lvl(1), lvl(0)}) << 16);
    if (a == PFS_OFF_STATUS) e = int'(eeprom_loaded) | (strap << 8);
    #1;
    `CHK("reg_rdata", e[31:0], reg_rdata)
  endtask
  task automatic do_reset(input logic s);
    @(posedge clock);
    reset_n <= 1'b0;
    ext_enable[0] <= 1'b1;
    ext_value[0] <= s;
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    foreach (regs[k]) regs[k] = 0;
    strap = s;
    regs[5] = s;
    @(posedge clock);
    ext_enable[0] <= 1'b0;
  endtask
  task automatic check_pins();
    logic [1:0] g;
    logic       drv;
    repeat (3) @(posedge clock);
    #1;
    drv = regs[0][1:0] == PFS_MSEL_MII_PHY && !regs[0][2];
    `CHK("col_oe", drv, port1_collision_pin_oe)
    `CHK("crs_oe", drv, port1_carrier_sense_pin_oe)
    if (drv) `CHK("col_out", core_collision, port1_collision_pin_out)
    if (drv) `CHK("crs_out", core_carrier, port1_carrier_sense_pin_out)
    `CHK("col_in", regs[0][1:0] == 0 && port1_collision_pin_in, sensed_collision)
    `CHK("sl_oe", eeprom_loaded && slave_data_drive_low, slave_serial_data_pin_oe)
    `CHK("sl_c", !eeprom_loaded || slave_serial_clock_pin, slave_clock_sensed)
    `CHK("sl_d", !eeprom_loaded || slave_serial_data_pin_in, slave_data_sensed)
    `CHK("ee_c_oe", eeprom_active && eeprom_clock_drive_low, eeprom_clock_pin_oe)
    `CHK("ee_d_oe", eeprom_active && eeprom_data_drive_low, eeprom_data_pin_oe)
    `CHK("ee_c", eeprom_clock_pin_in, eeprom_clock_sensed)
    `CHK("ee_d", eeprom_data_pin_in, eeprom_data_sensed)
    `CHK("phy_sel", regs[5][0], phy_address_select)
    for (int i = 0; i < 3; i++) begin
      g = exp_gp(i);
      `CHK("gp_oe", g[1], general_pin_oe[i])
      if (g[1]) `CHK("gp_out", g[0], general_pin_out[i])
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ==========
  // clock, watchdog, tests
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    repeat (5000) @(posedge clock);
    n_mismatch++;
    $display("watchdog expired");
    close_out();
  end
  initial begin
    {reset_n, reg_write, reg_read, core_collision, core_carrier, eeprom_loaded, eeprom_active,
     eeprom_clock_drive_low, eeprom_data_drive_low, slave_data_drive_low, indicator_5_value,
     phy_collision, master_data_low, eeprom_data_low, ext_enable, ext_value, reg_addr,
     reg_wdata} = '0;
    master_clock = 1'b1;
    void'($urandom(57));
    do_reset(1'b1);
    wr(PFS_OFF_STATUS, 32'hffffffff);
    wr(4'h9, 32'hffffffff);
    for (int a = 0; a < 10; a++) rd(a[3:0]);
    $display("test reset values done");
    for (int m = 0; m < 8; m++) begin
      @(posedge clock);
      rnd = $urandom;
      {phy_collision, core_collision, core_carrier} <= rnd[2:0];
      wr(PFS_OFF_PORT_CTRL, m[31:0]);
      check_pins();
      rd(PFS_OFF_PORT_CTRL);
    end
    $display("test port modes done");
    for (int k = 0; k < 12; k++) begin
      @(posedge clock);
      rnd = $urandom;
      ext_value <= rnd[26:24];
      ext_enable <= rnd[29:27] & ~rnd[2:0];
      wr(PFS_OFF_GP_CFG, rnd >> 4);
      wr(PFS_OFF_GP_DIR, rnd);
      check_pins();
      rd(PFS_OFF_GP_DIR);
      rd(PFS_OFF_GP_CFG);
    end
    $display("test general pins done");
    for (int f = 0; f < 16; f++) begin
      @(posedge clock);
      rnd = $urandom;
      indicator_5_value <= rnd[0];
      wr(PFS_OFF_IND_CFG, {23'h0, f[3], 5'h0, f[2:0]});
      check_pins();
      rd(PFS_OFF_IND_CFG);
    end
    $display("test indicator done");
    for (int k = 0; k < 8; k++) begin
      @(posedge clock);
      rnd = $urandom;
      eeprom_loaded <= k > 1;
      eeprom_active <= rnd[0];
      eeprom_clock_drive_low <= rnd[0] & rnd[1];
      eeprom_data_drive_low <= rnd[0] & rnd[2];
      {eeprom_data_low, slave_data_drive_low, master_data_low, master_clock} <= rnd[6:3];
      check_pins();
      rd(PFS_OFF_STATUS);
    end
    $display("test serial pins done");
    do_reset(1'b0);
    rd(PFS_OFF_STATUS);
    rd(PFS_OFF_SOFTSTRAP);
    wr(PFS_OFF_SOFTSTRAP, 32'h1);
    rd(PFS_OFF_SOFTSTRAP);
    check_pins();
    $display("test strap capture done");
    close_out();
  end
endmodule // pin_function_and_strap_control_bench
